// [verification/ingress_chk.sv]
// assertion checker for the ingress priority block
`timescale 1ns/1ps
module ingress_chk #(
	parameter PORTS = 3
) (
	input wire sys_clk,
	input wire rstn,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_rvalid,
	input wire pkt_valid,
	input wire [1:0] pkt_src_port,
	input wire pkt_broadcast,
	input wire lookup_hit,
	input wire lookup_pri_en,
	input wire [2:0] lookup_pri,
	input wire [2:0] res_tx_pri,
	input wire res_drop,
	input wire [PORTS-1:0] res_fwd_mask,
	input wire res_vlan_rules_on,
	input wire counter_test_mode,
	input wire [31:0] counter_read_load
);
	reg [15:0] cfg_ff;
	// shadow of the config word, updated on the same edge as the block's copy
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			cfg_ff <= 16'h0006;
		else if (reg_wr && reg_addr == 16'h1840)
			cfg_ff <= reg_wdata[15:0];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	lookup_first_a: assert property (pkt_valid && cfg_ff[5] && lookup_hit && lookup_pri_en |=>
		res_tx_pri == $past(lookup_pri)) else $error("lookup priority not used");
	vlan_gate_a: assert property (pkt_valid |=> res_vlan_rules_on == $past(cfg_ff[0]))
		else $error("vlan rule enable wrong");
	bcast_exempt_a: assert property (pkt_valid && pkt_broadcast |=> !res_drop)
		else $error("broadcast dropped");
	no_echo_a: assert property (pkt_valid && !cfg_ff[13] |=> !res_fwd_mask[$past(pkt_src_port)])
		else $error("packet echoed to source");
	cnt_mode_a: assert property (reg_wr && reg_addr == 16'h1840 |=> ##1
		counter_test_mode == $past(reg_wdata[6], 2)) else $error("counter test mode wrong");
	cnt_load_a: assert property (counter_read_load == (counter_test_mode ? 32'h7FFF_FFFC : 32'h0000_0000))
		else $error("counter load value wrong");
	rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved");
	rvalid_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
endmodule

bind switch_ingress_priority_config ingress_chk #(.PORTS(PORTS)) chk_i (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid),
	.pkt_valid(pkt_valid),
	.pkt_src_port(pkt_src_port),
	.pkt_broadcast(pkt_broadcast),
	.lookup_hit(lookup_hit),
	.lookup_pri_en(lookup_pri_en),
	.lookup_pri(lookup_pri),
	.res_tx_pri(res_tx_pri),
	.res_drop(res_drop),
	.res_fwd_mask(res_fwd_mask),
	.res_vlan_rules_on(res_vlan_rules_on),
	.counter_test_mode(counter_test_mode),
	.counter_read_load(counter_read_load)
);

// [verification/testbench.sv]
// self-checking bench for the ingress priority block
`timescale 1ns/1ps
module testbench;
	reg sys_clk, rstn, reg_wr, reg_rd, pkt_valid, pkt_tagged, pkt_is_ip, pkt_is_ipv4, pkt_is_igmp;
	reg pkt_multicast, pkt_broadcast, lookup_hit, lookup_pri_en;
	reg [15:0] reg_addr;
	reg [31:0] reg_wdata;
	reg [1:0] pkt_src_port;
	reg [2:0] pkt_tag_pri, port_default_pri, lookup_pri, lookup_fwd_mask;
	reg [11:0] pkt_tag_vid, port_default_vlan_id;
	reg [7:0] pkt_tos;
	wire [31:0] reg_rdata, counter_read_load;
	wire reg_rvalid, res_valid, res_drop, res_vlan_rules_on, res_igmp_redirect, counter_test_mode;
	wire [2:0] res_tx_pri, res_fwd_mask;
	wire [11:0] res_vid;
	integer err_total = 0;
	integer samples_checked = 0;
	integer i;
	switch_ingress_priority_config uut (
		.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pkt_valid(pkt_valid), .pkt_src_port(pkt_src_port), .pkt_tagged(pkt_tagged),
		.pkt_tag_pri(pkt_tag_pri), .pkt_tag_vid(pkt_tag_vid), .port_default_vlan_id(port_default_vlan_id),
		.port_default_pri(port_default_pri), .pkt_is_ip(pkt_is_ip), .pkt_is_ipv4(pkt_is_ipv4),
		.pkt_tos(pkt_tos), .pkt_is_igmp(pkt_is_igmp), .pkt_multicast(pkt_multicast),
		.pkt_broadcast(pkt_broadcast), .lookup_hit(lookup_hit), .lookup_pri_en(lookup_pri_en),
		.lookup_pri(lookup_pri), .lookup_fwd_mask(lookup_fwd_mask), .res_valid(res_valid),
		.res_tx_pri(res_tx_pri), .res_drop(res_drop), .res_fwd_mask(res_fwd_mask), .res_vid(res_vid),
		.res_vlan_rules_on(res_vlan_rules_on), .res_igmp_redirect(res_igmp_redirect),
		.counter_test_mode(counter_test_mode), .counter_read_load(counter_read_load)
	);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// strobes stay high across back-to-back calls; idle drops them
	task wr(input [15:0] a, input [31:0] d);
		begin
			reg_rd = 1'b0;
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(negedge sys_clk);
		end
	endtask
	task rc(input [15:0] a, input [31:0] e);
		begin
			reg_wr = 1'b0;
			reg_addr = a;
			reg_rd = 1'b1;
			@(negedge sys_clk);
			chk(reg_rvalid, 1);
			chk(reg_rdata, e);
		end
	endtask
	task idle(input integer n);
		begin
			reg_wr = 1'b0;
			reg_rd = 1'b0;
			repeat (n) @(negedge sys_clk);
		end
	endtask
	task tw(input [5:0] x, input [2:0] v);
		begin
			wr(16'h1812, v);
			wr(16'h1811, x);
			idle(2);
		end
	endtask
	task tr(input [5:0] x, input [2:0] v);
		begin
			wr(16'h1811, 32'h80 | x);
			idle(2);
			rc(16'h1813, v);
		end
	endtask
	task pk(input [15:0] c, input [2:0] p, input d, input [2:0] m);
		begin
			wr(16'h1840, c);
			reg_wr = 1'b0;
			pkt_valid = 1'b1;
			@(negedge sys_clk) pkt_valid = 1'b0;
			chk(res_valid, 1);
			chk(res_tx_pri, p);
			chk(res_drop, d);
			chk(res_fwd_mask, m);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		#50000;
		err_total = err_total + 1;
		conclude;
	end
	initial begin
		{reg_wr, reg_rd, pkt_valid, pkt_tagged, pkt_is_ip, pkt_multicast, pkt_broadcast, pkt_is_igmp} = 8'h00;
		{lookup_pri_en, reg_addr, reg_wdata} = 49'h0;
		{pkt_is_ipv4, lookup_hit, pkt_src_port, port_default_pri, lookup_fwd_mask} = 10'h35F;
		{pkt_tag_pri, lookup_pri, pkt_tos} = 14'h2AD8;
		{port_default_vlan_id, pkt_tag_vid} = 24'h123456;
		rstn = 1'b0;
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		rc(16'h1840, 32'h6);
		rc(16'h1813, 0);
		rc(16'h1814, 0);
		rc(16'h1850, 0);
		wr(16'h1840, 32'hFFFF_FFFF);
		idle(2);
		chk(counter_read_load, 32'h7FFF_FFFC);
		chk(counter_test_mode, 1);
		rc(16'h1840, 32'hFFFF);
		wr(16'h1840, 0);
		idle(2);
		chk(counter_read_load, 0);
		chk(counter_test_mode, 0);
		$display("register test done");
		for (i = 0; i < 8; i = i + 1)
			tw(6'(i * 9), 3'(i + 3));
		for (i = 0; i < 8; i = i + 1)
			tr(6'(i * 9), 3'(i + 3));
		wr(16'h1812, 5);
		wr(16'h1811, 32'h2A);
		wr(16'h1812, 7);
		rc(16'h1814, 1);
		rc(16'h1814, 0);
		rc(16'h1813, 2);
		tr(6'h2A, 5);
		wr(16'h1811, 32'h2B);
		idle(2);
		tr(6'h2B, 5);
		wr(16'h1813, 32'hFFFF_FFFF);
		rc(16'h1813, 5);
		$display("table test done");
		pk(16'h0000, 3, 0, 3'h5);
		chk(res_vlan_rules_on, 0);
		pk(16'h0001, 3, 0, 3'h5);
		chk(res_vlan_rules_on, 1);
		pkt_tagged = 1'b1;
		pk(16'h4000, 5, 0, 3'h5);
		chk(res_vid, 12'h456);
		pk(16'hC000, 5, 0, 3'h5);
		chk(res_vid, 12'h123);
		pkt_is_ip = 1'b1;
		pk(16'h4206, 5, 0, 3'h5);
		pk(16'h4204, 6, 0, 3'h5);
		pk(16'h0200, 1, 0, 3'h5);
		lookup_pri_en = 1'b1;
		pk(16'h0224, 2, 0, 3'h5);
		lookup_hit = 1'b0;
		pkt_multicast = 1'b1;
		pk(16'h0010, 3, 1, 3'h5);
		pkt_broadcast = 1'b1;
		pk(16'h0018, 3, 0, 3'h5);
		{pkt_multicast, pkt_broadcast} = 2'h0;
		pk(16'h0008, 3, 1, 3'h5);
		chk(res_igmp_redirect, 0);
		pkt_is_igmp = 1'b1;
		pk(16'h1880, 3, 0, 3'h4);
		pk(16'h3880, 3, 0, 3'h6);
		chk(res_igmp_redirect, 1);
		$display("packet test done");
		conclude;
	end
endmodule

// [verilog/ingress_priority_defs.vh]
// register map, field positions, reset values and timing counts for the ingress priority block
`ifndef INGRESS_PRIORITY_DEFS_VH
`define INGRESS_PRIORITY_DEFS_VH

`define REG_ADDR_W 16
`define OFS_TBL_COMMAND 16'h1811
`define OFS_TBL_WRITE_DATA 16'h1812
`define OFS_TBL_READ_DATA 16'h1813
`define OFS_TBL_CMD_STATUS 16'h1814
`define OFS_GLOBAL_INGRESS_CFG 16'h1840

`define CMD_READ_NOT_WRITE 7
`define CMD_INDEX_HI 5
`define CMD_INDEX_LO 0
`define TBL_PRI_HI 2
`define TBL_PRI_LO 0
`define STS_PENDING 0

`define CFG_TAG_VID_IGNORE 15
`define CFG_TAG_PRI_USE 14
`define CFG_MONITOR_ECHO 13
`define CFG_IGMP_PORTS_HI 12
`define CFG_IGMP_PORTS_LO 10
`define CFG_IP_PRI_USE 9
`define CFG_IGMP_SNOOP 7
`define CFG_COUNTER_TEST 6
`define CFG_DA_PRI_FIRST 5
`define CFG_MCAST_FILTER 4
`define CFG_UNKNOWN_UCAST_DROP 3
`define CFG_PRECEDENCE_SEL 2
`define CFG_TAG_OVER_IP 1
`define CFG_VLAN_RULES_EN 0

`define CFG_WIDTH 16
`define CFG_RESET 16'h0006
`define CMD_RESET 8'h00
`define WDATA_RESET 3'h0
`define RDATA_RESET 3'h0
`define COUNTER_TEST_VALUE 32'h7FFF_FFFC
`define COUNTER_CLEAR_VALUE 32'h0000_0000

// table command latency, in sys_clk cycles from the command write to completion
`define TBL_CMD_CYCLES 2

`endif

// [verilog/switch_ingress_priority_config.v]
// global ingress configuration, ip-priority table access and per-packet queue selection
// Functional notes
// - read data shows last read table priority
// - pending bit high while table command runs
// - tag vid ignored when enabled, port default vid used
// - tag priority may choose transmit queue
// - echo to source only for monitor packets
// - three-bit bitmap selects igmp redirect ports
// - ip tos/class may choose transmit queue
// - igmp snoop forwards igmp to monitor ports
// - counter test loads fixed value on read
// - lookup entry priority wins when enabled
// - drop unknown multicast, never broadcast
// - drop unknown unicast when enabled
// - precedence bits or table, reset one
// - tag beats ip when enabled, reset one
// - vlan rules only when enabled, reset off
// - command write starts indexed read or write
`timescale 1ns/1ps
`include "ingress_priority_defs.vh"

module switch_ingress_priority_config #(
	parameter TBL_DEPTH = 64,
	parameter TBL_IDX_W = 6,
	parameter PORTS = 3,
	parameter CMD_CYCLES = `TBL_CMD_CYCLES
) (
	input wire sys_clk,
	input wire rstn,
	// management register port
	input wire [`REG_ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg reg_rvalid,
	// per-packet ingress classification request
	input wire pkt_valid,
	input wire [1:0] pkt_src_port,
	input wire pkt_tagged,
	input wire [2:0] pkt_tag_pri,
	input wire [11:0] pkt_tag_vid,
	input wire [11:0] port_default_vlan_id,
	input wire [2:0] port_default_pri,
	input wire pkt_is_ip,
	input wire pkt_is_ipv4,
	input wire [7:0] pkt_tos,
	input wire pkt_is_igmp,
	input wire pkt_multicast,
	input wire pkt_broadcast,
	input wire lookup_hit,
	input wire lookup_pri_en,
	input wire [2:0] lookup_pri,
	input wire [PORTS-1:0] lookup_fwd_mask,
	// classification result, one cycle after the request
	output reg res_valid,
	output reg [2:0] res_tx_pri,
	output reg res_drop,
	output reg [PORTS-1:0] res_fwd_mask,
	output reg [11:0] res_vid,
	output reg res_vlan_rules_on,
	output reg res_igmp_redirect,
	// global settings seen by the rest of the engine
	output reg counter_test_mode,
	output reg [31:0] counter_read_load
);

	localparam ST_IDLE = 2'b01;
	localparam ST_BUSY = 2'b10;
	localparam CNT_W = 8;
	// a zero count would wrap the counter and keep the sequencer busy for 256 cycles
	localparam integer CNT_LOAD = (CMD_CYCLES < 1) ? 1 : CMD_CYCLES;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [CNT_W-1:0] cnt_ff;
	reg [CNT_W-1:0] nxt_cnt;
	reg [`CFG_WIDTH-1:0] cfg_ff;
	reg [7:0] cmd_ff;
	reg [2:0] wdata_ff;
	reg [2:0] rdata_ff;
	reg pending_ff;
	reg nxt_pending;
	reg [2:0] table_mem [0:TBL_DEPTH-1];

	reg [31:0] nxt_rdata;
	reg [2:0] nxt_tx_pri;
	reg nxt_drop;
	reg [PORTS-1:0] nxt_fwd_mask;
	reg [PORTS-1:0] src_bit;
	reg nxt_redirect;
	reg tag_ok;
	reg ip_ok;
	reg [11:0] nxt_vid;
	wire cmd_write;
	wire cfg_write;
	wire wdata_write;
	wire cmd_done;
	wire [TBL_IDX_W-1:0] cmd_index;
	wire [TBL_IDX_W-1:0] dscp_index;
	wire [2:0] table_pri;
	wire mcast_only;
	wire da_miss;

	// field picker shared by the packet and counter-setting paths
	function cfg_bit;
		input [`CFG_WIDTH-1:0] cfg;
		input integer pos;
		begin
			cfg_bit = cfg[pos];
		end
	endfunction

	// register decode shared by every write path
	function reg_hit;
		input [`REG_ADDR_W-1:0] addr;
		input [`REG_ADDR_W-1:0] ofs;
		begin
			reg_hit = (addr == ofs);
		end
	endfunction

	// the igmp field is three bits wide; other port counts are cut or padded here
	function [PORTS-1:0] fit_ports;
		input [2:0] bits;
		integer k;
		begin
			fit_ports = {PORTS{1'b0}};
			for (k = 0; k < PORTS; k = k + 1) begin
				if (k < 3) begin
					fit_ports[k] = bits[k];
				end
			end
		end
	endfunction

	assign cmd_index = cmd_ff[`CMD_INDEX_HI:`CMD_INDEX_LO];
	assign dscp_index = pkt_tos[7:2];
	// entries never written read as unknown; the host fills the table first
	assign table_pri = table_mem[dscp_index];
	// a command arriving while one runs is dropped, so the index of the running one cannot move
	assign cmd_write = reg_wr && reg_hit(reg_addr, `OFS_TBL_COMMAND) && (state_ff == ST_IDLE);
	assign cmd_done = (state_ff == ST_BUSY) && (cnt_ff == 8'h01);
	assign cfg_write = reg_wr && reg_hit(reg_addr, `OFS_GLOBAL_INGRESS_CFG);
	// write data is frozen while a command runs so a write lands what was loaded first
	assign wdata_write = reg_wr && reg_hit(reg_addr, `OFS_TBL_WRITE_DATA) && (state_ff == ST_IDLE);
	// broadcast also raises the multicast flag, so it is split out before either filter
	assign mcast_only = pkt_multicast && !pkt_broadcast;
	assign da_miss = !lookup_hit;

	// table command sequencer
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_pending = pending_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cmd_write) begin
					nxt_state = ST_BUSY;
					nxt_cnt = CNT_LOAD[CNT_W-1:0];
					nxt_pending = 1'b1;
				end
			end
			ST_BUSY: begin
				if (cmd_done) begin
					nxt_state = ST_IDLE;
					nxt_cnt = 8'h00;
					nxt_pending = 1'b0;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = 8'h00;
				nxt_pending = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 8'h00;
			pending_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pending_ff <= nxt_pending;
		end
	end

	// software-written registers
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= `CFG_RESET;
			cmd_ff <= `CMD_RESET;
			wdata_ff <= `WDATA_RESET;
		end else begin
			if (cfg_write) begin
				cfg_ff <= reg_wdata[`CFG_WIDTH-1:0];
			end
			if (cmd_write) begin
				// bit 6 is reserved and always reads zero
				cmd_ff <= {reg_wdata[`CMD_READ_NOT_WRITE], 1'b0, reg_wdata[`CMD_INDEX_HI:`CMD_INDEX_LO]};
			end
			if (wdata_write) begin
				wdata_ff <= reg_wdata[`TBL_PRI_HI:`TBL_PRI_LO];
			end
		end
	end

	// the table itself is not reset; software must fill it before relying on it
	always @(posedge sys_clk) begin
		if (cmd_done && !cmd_ff[`CMD_READ_NOT_WRITE]) begin
			table_mem[cmd_index] <= wdata_ff;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= `RDATA_RESET;
		end else if (cmd_done && cmd_ff[`CMD_READ_NOT_WRITE]) begin
			rdata_ff <= table_mem[cmd_index];
		end
	end

	// register read mux; unmapped offsets answer zero
	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (reg_addr)
			`OFS_TBL_COMMAND: nxt_rdata = {24'h000000, cmd_ff};
			`OFS_TBL_WRITE_DATA: nxt_rdata = {29'h00000000, wdata_ff};
			`OFS_TBL_READ_DATA: nxt_rdata = {29'h00000000, rdata_ff};
			`OFS_TBL_CMD_STATUS: nxt_rdata = {31'h00000000, pending_ff};
			`OFS_GLOBAL_INGRESS_CFG: nxt_rdata = {16'h0000, cfg_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= nxt_rdata;
			end
		end
	end

	// transmit priority selection
	always @* begin
		tag_ok = cfg_bit(cfg_ff, `CFG_TAG_PRI_USE) && pkt_tagged;
		ip_ok = cfg_bit(cfg_ff, `CFG_IP_PRI_USE) && pkt_is_ip;
		nxt_tx_pri = port_default_pri;
		if (cfg_bit(cfg_ff, `CFG_DA_PRI_FIRST) && lookup_hit && lookup_pri_en) begin
			nxt_tx_pri = lookup_pri;
		end else if (tag_ok && (cfg_bit(cfg_ff, `CFG_TAG_OVER_IP) || !ip_ok)) begin
			nxt_tx_pri = pkt_tag_pri;
		end else if (ip_ok) begin
			if (pkt_is_ipv4 && cfg_bit(cfg_ff, `CFG_PRECEDENCE_SEL)) begin
				nxt_tx_pri = pkt_tos[7:5];
			end else begin
				// ipv6 has no precedence choice and always goes through the table
				nxt_tx_pri = table_pri;
			end
		end
	end

	// filtering and forwarding
	always @* begin
		nxt_drop = 1'b0;
		if (cfg_bit(cfg_ff, `CFG_MCAST_FILTER) && mcast_only && da_miss) begin
			nxt_drop = 1'b1;
		end
		if (cfg_bit(cfg_ff, `CFG_UNKNOWN_UCAST_DROP) && !pkt_multicast && !pkt_broadcast && da_miss) begin
			nxt_drop = 1'b1;
		end
		nxt_redirect = cfg_bit(cfg_ff, `CFG_IGMP_SNOOP) && pkt_is_igmp && pkt_is_ipv4;
		src_bit = {{(PORTS-1){1'b0}}, 1'b1} << pkt_src_port;
		if (nxt_redirect) begin
			nxt_fwd_mask = fit_ports(cfg_ff[`CFG_IGMP_PORTS_HI:`CFG_IGMP_PORTS_LO]);
		end else begin
			nxt_fwd_mask = lookup_fwd_mask;
		end
		// only a monitor packet with echo allowed may return to its own port
		if (!(nxt_redirect && cfg_bit(cfg_ff, `CFG_MONITOR_ECHO))) begin
			nxt_fwd_mask = nxt_fwd_mask & ~src_bit;
		end
	end

	// vlan id used by the vlan rules; the egress tag itself is left alone
	always @* begin
		nxt_vid = pkt_tag_vid;
		if (cfg_bit(cfg_ff, `CFG_TAG_VID_IGNORE) || !pkt_tagged) begin
			nxt_vid = port_default_vlan_id;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			res_valid <= 1'b0;
			res_tx_pri <= 3'h0;
			res_drop <= 1'b0;
			res_fwd_mask <= {PORTS{1'b0}};
			res_vid <= 12'h000;
			res_vlan_rules_on <= 1'b0;
			res_igmp_redirect <= 1'b0;
		end else begin
			res_valid <= pkt_valid;
			if (pkt_valid) begin
				res_tx_pri <= nxt_tx_pri;
				res_drop <= nxt_drop;
				res_fwd_mask <= nxt_fwd_mask;
				res_igmp_redirect <= nxt_redirect;
				res_vlan_rules_on <= cfg_bit(cfg_ff, `CFG_VLAN_RULES_EN);
				res_vid <= nxt_vid;
			end
		end
	end

	// read-clear counters elsewhere load this value on each read
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			counter_test_mode <= 1'b0;
			counter_read_load <= `COUNTER_CLEAR_VALUE;
		end else begin
			counter_test_mode <= cfg_bit(cfg_ff, `CFG_COUNTER_TEST);
			if (cfg_bit(cfg_ff, `CFG_COUNTER_TEST)) begin
				counter_read_load <= `COUNTER_TEST_VALUE;
			end else begin
				counter_read_load <= `COUNTER_CLEAR_VALUE;
			end
		end
	end

endmodule
